/* rtl/fbepc_host.sv */
// Purpose: host-side block erase and protection controller for a boot-block flash
// Assumes: flash pins synchronous to hclk, one AHB-Lite master
// Notes: flash command bytes for erase, confirm and suspend are parameters
`timescale 1ns/1ps
`include "fbepc_regs.svh"

module fbepc_host #(
	parameter int ADDR_W = 18,
	parameter int DQ_W = 16,
	parameter int WE_CYC = `FBEPC_WE_CYC,
	parameter int RD_CYC = `FBEPC_RD_CYC,
	parameter logic [7:0] CMD_ERASE = 8'h20,
	parameter logic [7:0] CMD_CONFIRM = 8'hD0,
	parameter logic [7:0] CMD_SUSPEND = 8'hB0,
	parameter logic [7:0] CMD_RESUME = 8'hD0,
	parameter int SUSP_BIT = 6
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// flash bus
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic [ADDR_W-1:0] flash_addr,
	input wire logic [DQ_W-1:0] flash_dq_i,
	output logic [DQ_W-1:0] flash_dq_o,
	output logic flash_dq_oe,
	// flash protection and power pins
	output logic reset_powerdown_n,
	output logic high_voltage_unlock_en,
	output logic flash_wp_n,
	output logic flash_vpp_en
);
	import fbepc_pkg::*;

	localparam logic [7:0] WE_LAST = 8'(WE_CYC - 1);
	localparam logic [7:0] RD_LAST = 8'(RD_CYC - 1);

	typedef struct packed {
		fbepc_state_t st;
		logic [7:0] cnt;
		logic rd;
		logic [2:0] op;
		logic [2:0] step;
		logic busy;
		logic susp;
		logic susp_req;
		logic refused;
		logic [7:0] sr;
		logic [DQ_W-1:0] rdata;
		logic wp_n;
		logic hv;
		logic vpp;
		logic pd;
		logic [ADDR_W-1:0] addr;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [ADDR_W-1:0] fa;
		logic [DQ_W-1:0] dq_o;
		logic dq_oe;
		logic dph_wr;
		logic [1:0] dph_a;
		logic [31:0] hrdata;
		logic hreadyout;
		logic rpn;
		logic hv_en;
	} fbepc_regs_t;

	fbepc_regs_t r, n;

	// ==========================================
	// command plan of each operation
	function automatic fbepc_act_t plan(input logic [2:0] op, input logic [2:0] step);
		fbepc_act_t a;
		a.kind = K_DONE;
		a.data = 8'h00;
		case (op)
			`FBEPC_OP_ERASE: begin
				case (step)
					3'h0: a = '{K_WR, `FBEPC_CMD_CLRSTAT};
					3'h1: a = '{K_WR, CMD_ERASE};
					3'h2: a = '{K_WR, CMD_CONFIRM};
					3'h3: a = '{K_WR, `FBEPC_CMD_RDSTAT};
					3'h4: a = '{K_POLL, 8'h00};
					3'h5: a = '{K_WR, `FBEPC_CMD_RDARRAY};
					default: a = '{K_DONE, 8'h00};
				endcase
			end
			`FBEPC_OP_SUSP: begin
				case (step)
					3'h0: a = '{K_WR, CMD_SUSPEND};
					3'h1: a = '{K_WR, `FBEPC_CMD_RDSTAT};
					3'h2: a = '{K_POLL, 8'h00};
					default: a = '{K_DONE, 8'h00};
				endcase
			end
			`FBEPC_OP_RESUME: begin
				case (step)
					3'h0: a = '{K_WR, CMD_RESUME};
					3'h1: a = '{K_WR, `FBEPC_CMD_RDSTAT};
					3'h2: a = '{K_POLL, 8'h00};
					3'h3: a = '{K_WR, `FBEPC_CMD_RDARRAY};
					default: a = '{K_DONE, 8'h00};
				endcase
			end
			`FBEPC_OP_RDSTAT: begin
				case (step)
					3'h0: a = '{K_WR, `FBEPC_CMD_RDSTAT};
					3'h1: a = '{K_RD, 8'h00};
					default: a = '{K_DONE, 8'h00};
				endcase
			end
			`FBEPC_OP_CLRSTAT: begin
				case (step)
					3'h0: a = '{K_WR, `FBEPC_CMD_CLRSTAT};
					default: a = '{K_DONE, 8'h00};
				endcase
			end
			`FBEPC_OP_READ: begin
				case (step)
					3'h0: a = '{K_WR, `FBEPC_CMD_RDARRAY};
					3'h1: a = '{K_RD, 8'h00};
					default: a = '{K_DONE, 8'h00};
				endcase
			end
			default: a = '{K_DONE, 8'h00};
		endcase
		return a;
	endfunction

	// ops allowed while the erase is suspended
	function automatic logic susp_ok(input logic [2:0] op);
		return op == `FBEPC_OP_READ || op == `FBEPC_OP_RESUME || op == `FBEPC_OP_RDSTAT;
	endfunction

	function automatic logic [31:0] rd_mux(input fbepc_regs_t s, input logic [1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			`FBEPC_CTRL: begin
				v[`FBEPC_CTRL_OP_LSB +: 3] = s.op;
				v[`FBEPC_CTRL_WPN] = s.wp_n;
				v[`FBEPC_CTRL_HV] = s.hv;
				v[`FBEPC_CTRL_VPP] = s.vpp;
				v[`FBEPC_CTRL_PD] = s.pd;
			end
			`FBEPC_ADDR: v[ADDR_W-1:0] = s.addr;
			`FBEPC_STAT: v = {16'h0000, s.sr, 3'h0, s.sr[`FBEPC_SR_VPP],
				s.sr[`FBEPC_SR_ERASE], s.refused, s.susp, s.busy};
			default: v[DQ_W-1:0] = s.rdata;
		endcase
		return v;
	endfunction

	fbepc_act_t act;
	logic [2:0] wop;
	logic last;

	// ==========================================
	// next state
	always_comb begin
		n = r;
		act = plan(r.op, r.step);
		wop = hwdata[`FBEPC_CTRL_OP_LSB +: 3];
		last = 1'b0;
		// ahb address phase, zero wait states
		n.dph_wr = 1'b0;
		if (hsel && hready && htrans[1]) begin
			n.dph_wr = hwrite;
			n.dph_a = haddr[3:2];
			n.hrdata = rd_mux(r, haddr[3:2]);
		end
		// ahb data phase write
		if (r.dph_wr) begin
			case (r.dph_a)
				`FBEPC_CTRL: begin
					n.wp_n = hwdata[`FBEPC_CTRL_WPN];
					n.hv = hwdata[`FBEPC_CTRL_HV];
					n.vpp = hwdata[`FBEPC_CTRL_VPP];
					n.pd = hwdata[`FBEPC_CTRL_PD];
					if (wop != `FBEPC_OP_NONE) begin
						if (hwdata[`FBEPC_CTRL_PD] || r.pd) begin
							n.refused = 1'b1;
						end else if (r.busy && wop == `FBEPC_OP_SUSP
							&& r.op == `FBEPC_OP_ERASE) begin
							n.susp_req = 1'b1;
						end else if (r.busy || (r.susp && !susp_ok(wop))
							|| (!r.susp && wop == `FBEPC_OP_RESUME)) begin
							n.refused = 1'b1;
						end else begin
							n.op = wop;
							n.step = 3'h0;
							n.busy = 1'b1;
							n.refused = 1'b0;
						end
					end
				end
				`FBEPC_ADDR: n.addr = hwdata[ADDR_W-1:0];
				default: begin
				end
			endcase
		end
		// flash bus sequencer
		case (r.st)
			ST_IDLE: begin
				if (r.pd) begin
					n.busy = 1'b0;
					n.susp = 1'b0;
					n.susp_req = 1'b0;
					n.sr = 8'h00;
				end else if (r.busy) begin
					if (r.susp_req && act.kind == K_POLL) begin
						n.op = `FBEPC_OP_SUSP;
						n.step = 3'h0;
						n.susp_req = 1'b0;
					end else if (act.kind == K_DONE) begin
						n.busy = 1'b0;
						n.susp_req = 1'b0;
					end else begin
						n.ce_n = 1'b0;
						n.fa = r.addr;
						n.rd = act.kind != K_WR;
						n.dq_oe = act.kind == K_WR;
						n.dq_o = DQ_W'(act.data);
						n.st = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				n.we_n = r.rd;
				n.oe_n = !r.rd;
				n.cnt = 8'h00;
				n.st = ST_STROBE;
			end
			ST_STROBE: begin
				n.cnt = r.cnt + 8'h01;
				last = r.rd ? (r.cnt == RD_LAST) : (r.cnt == WE_LAST);
				if (last) begin
					n.we_n = 1'b1;
					n.oe_n = 1'b1;
					n.st = ST_RECOVER;
					n.step = r.step + 3'h1;
					if (r.rd) begin
						n.rdata = flash_dq_i;
						if (act.kind != K_RD || r.op == `FBEPC_OP_RDSTAT) begin
							n.sr = flash_dq_i[7:0];
						end
					end
					if (act.kind == K_POLL) begin
						if (!flash_dq_i[`FBEPC_SR_READY]) begin
							n.step = r.step;
						end else if (r.op == `FBEPC_OP_SUSP) begin
							n.susp = flash_dq_i[SUSP_BIT];
						end else begin
							n.susp = 1'b0;
						end
					end
				end
			end
			ST_RECOVER: begin
				n.ce_n = 1'b1;
				n.dq_oe = 1'b0;
				n.st = ST_IDLE;
			end
			default: n.st = ST_IDLE;
		endcase
		// power pins follow the power-down bit in the same cycle, from flops
		n.rpn = !n.pd;
		n.hv_en = n.hv && !n.pd;
	end

	// ==========================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.wp_n <= 1'b1;
			r.pd <= 1'b1;
			r.ce_n <= 1'b1;
			r.we_n <= 1'b1;
			r.oe_n <= 1'b1;
			r.hreadyout <= 1'b1;
		end else begin
			r <= n;
			r.hreadyout <= 1'b1;
		end
	end

	// ==========================================
	// outputs
	assign hrdata = r.hrdata;
	assign hreadyout = r.hreadyout;
	assign hresp = 1'b0;
	assign flash_ce_n = r.ce_n;
	assign flash_we_n = r.we_n;
	assign flash_oe_n = r.oe_n;
	assign flash_addr = r.fa;
	assign flash_dq_o = r.dq_o;
	assign flash_dq_oe = r.dq_oe;
	assign reset_powerdown_n = r.rpn;
	assign high_voltage_unlock_en = r.hv_en;
	assign flash_wp_n = r.wp_n;
	assign flash_vpp_en = r.vpp;

endmodule

/* rtl/fbepc_regs.svh */
// Purpose: register map, field positions and command codes of the erase controller
// Assumes: AHB-Lite word registers, flash command set on the low data byte
// Notes: included by the controller only
//
// Overview of operation
// - erase: set-up write, then confirm at block
// - read-array command after every erase
// - clear status before each new erase
// - while suspended: read, resume, status only
// - chip select first, then resume write
// - writes only with strobe and select low
// - clear-status or power-down clears error bits
`ifndef FBEPC_REGS_SVH
`define FBEPC_REGS_SVH

// register word indices (haddr[3:2])
`define FBEPC_CTRL 2'h0
`define FBEPC_ADDR 2'h1
`define FBEPC_STAT 2'h2
`define FBEPC_DATA 2'h3

// control register fields
`define FBEPC_CTRL_OP_LSB 0
`define FBEPC_CTRL_WPN 8
`define FBEPC_CTRL_HV 9
`define FBEPC_CTRL_VPP 10
`define FBEPC_CTRL_PD 11
`define FBEPC_CTRL_RST 4'h1

// operation codes
`define FBEPC_OP_NONE 3'h0
`define FBEPC_OP_ERASE 3'h1
`define FBEPC_OP_SUSP 3'h2
`define FBEPC_OP_RESUME 3'h3
`define FBEPC_OP_RDSTAT 3'h4
`define FBEPC_OP_CLRSTAT 3'h5
`define FBEPC_OP_READ 3'h6

// flash command codes
`define FBEPC_CMD_RDSTAT 8'h70
`define FBEPC_CMD_CLRSTAT 8'h50
`define FBEPC_CMD_RDARRAY 8'hFF

// flash status bits
`define FBEPC_SR_READY 7
`define FBEPC_SR_ERASE 5
`define FBEPC_SR_VPP 3

// strobe widths in clock cycles
`define FBEPC_WE_CYC 3
`define FBEPC_RD_CYC 4

`endif

/* rtl/fbepc_pkg.sv */
// Purpose: types of the erase controller
// Assumes: nothing
// Notes: state struct lives in the module, it depends on parameters
package fbepc_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} fbepc_state_t;

	typedef enum logic [1:0] {K_DONE, K_WR, K_RD, K_POLL} fbepc_kind_t;

	typedef struct packed {
		fbepc_kind_t kind;
		logic [7:0] data;
	} fbepc_act_t;

endpackage

/* bench/fbepc_flash_model.sv */
// Purpose: behavioural boot-block flash for the erase controller bench
// Assumes: pins move on hclk edges; block index is addr[17:15]
// Notes: erase time shortened; fail forces a verify failure
`timescale 1ns/1ps
module fbepc_flash_model #(
	parameter int ERASE_T = 200,
	parameter logic [2:0] BOOT = 3'h7
) (
	// clock
	input wire logic hclk,
	// flash pins
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [17:0] addr,
	input wire logic [15:0] din,
	input wire logic rp_n,
	input wire logic hv,
	input wire logic wp_n,
	input wire logic vpp,
	input wire logic fail,
	output logic [15:0] dout
);
	// ==========
	// command decoder and write state machine
	logic [7:0] sr;
	logic [15:0] cnt;
	logic [15:0] last = 16'h0;
	logic [2:0] blk = 3'h0;
	logic [2:0] erased = 3'h7;
	logic setup, stat_mode, susp, we_q, drv, done;
	logic [15:0] val;
	assign drv = rp_n && !ce_n && !oe_n;
	assign val = stat_mode ? {8'h00, sr} : (addr[17:15] == erased ? 16'hFFFF : addr[15:0]);
	// released bus shows the inverse of its last value
	assign dout = drv ? val : ~last;
	assign done = cnt == 16'h1;
	always @(posedge hclk or negedge rp_n) begin
		if (!rp_n) begin
			sr <= 8'h80;
			cnt <= '0;
			setup <= 1'b0;
			stat_mode <= 1'b0;
			susp <= 1'b0;
			we_q <= 1'b1;
		end else begin
			we_q <= we_n;
			if (drv)
				last <= val;
			if (cnt != 0 && !susp) begin
				cnt <= cnt - 16'h1;
				sr[7] <= done;
				sr[5] <= sr[5] | (done && fail);
				if (done && !fail)
					erased <= blk;
			end
			if (we_n && !we_q && !ce_n) begin
				setup <= 1'b0;
				case (din[7:0])
				8'h20: setup <= !susp;
				8'h70: stat_mode <= 1'b1;
				8'h50: sr[5:3] <= 3'b000;
				8'hFF: stat_mode <= 1'b0;
				8'hB0: if (cnt != 0) begin
					susp <= 1'b1;
					sr[7:6] <= 2'b11;
				end
				8'hD0: if (susp) begin
					susp <= 1'b0;
					sr[7:6] <= 2'b00;
				end else if (setup) begin
					stat_mode <= 1'b1;
					blk <= addr[17:15];
					if (!vpp)
						sr[5:3] <= sr[5:3] | 3'b101;
					else if (addr[17:15] == BOOT && !wp_n && !hv)
						sr[5] <= 1'b1;
					else begin
						cnt <= 16'(ERASE_T);
						sr[7] <= 1'b0;
					end
				end
				default: ;
				endcase
			end
		end
	end
endmodule

/* bench/fbepc_host_checker.sv */
// Purpose: flash pin timing checks of the erase controller
// Assumes: strobe widths handed on from the controller
// Notes: bound to every controller instance
`timescale 1ns/1ps
module fbepc_host_checker #(
	parameter int WE_CYC = 3,
	parameter int RD_CYC = 4
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// flash pins
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic flash_dq_oe,
	input wire logic reset_powerdown_n,
	input wire logic high_voltage_unlock_en
);
	// ==========
	// strobe width counters
	logic [7:0] we_cnt;
	logic [7:0] oe_cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			we_cnt <= '0;
			oe_cnt <= '0;
		end else begin
			we_cnt <= flash_we_n ? 8'h00 : we_cnt + 8'h01;
			oe_cnt <= flash_oe_n ? 8'h00 : oe_cnt + 8'h01;
		end
	end
	// ==========
	// properties
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_wr_close;
		flash_we_n && !flash_ce_n ##1 flash_ce_n && !flash_dq_oe;
	endsequence
	sequence s_pd_long;
		!reset_powerdown_n [*8];
	endsequence
	a_we_select: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
		else $error("strobe without select");
	a_we_width: assert property ($rose(flash_we_n) |-> we_cnt == WE_CYC)
		else $error("write strobe width");
	a_wr_close: assert property ($rose(flash_we_n) |-> s_wr_close)
		else $error("write cycle close");
	a_ce_idle: assert property ($fell(flash_ce_n) |-> flash_we_n && flash_oe_n)
		else $error("cycle starts with a strobe low");
	a_rd_width: assert property ($rose(flash_oe_n) |-> oe_cnt == RD_CYC)
		else $error("read strobe width");
	a_rd_clean: assert property ($fell(flash_oe_n) |-> flash_we_n && !flash_ce_n && !flash_dq_oe)
		else $error("read with write or no select");
	a_pd_quiet: assert property (s_pd_long |-> flash_ce_n && !flash_dq_oe)
		else $error("activity in power-down");
	a_hv_awake: assert property (!reset_powerdown_n [*3] |-> !high_voltage_unlock_en)
		else $error("high voltage in power-down");
endmodule

bind fbepc_host fbepc_host_checker #(.WE_CYC(WE_CYC), .RD_CYC(RD_CYC)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
	.flash_oe_n(flash_oe_n), .flash_dq_oe(flash_dq_oe), .reset_powerdown_n(reset_powerdown_n),
	.high_voltage_unlock_en(high_voltage_unlock_en)
);

/* bench/tb.sv */
// Purpose: self-checking bench of the erase and protection controller
// Assumes: one AHB-Lite master, flash model on the far side
// Notes: ctl argument is {PD, VPP, HV, WPN}
`timescale 1ns/1ps
module tb;
	logic hclk, hresetn, hwrite, fail, hreadyout, hresp;
	logic ce_n, we_n, oe_n, dq_oe, rp_n, hv, wp_n, vpp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [17:0] fa;
	logic [15:0] dq_i, dq_o;
	int fail_count = 0;
	int compares = 0;
	fbepc_host #(.WE_CYC(3), .RD_CYC(4)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .flash_ce_n(ce_n), .flash_we_n(we_n),
		.flash_oe_n(oe_n), .flash_addr(fa), .flash_dq_i(dq_i), .flash_dq_o(dq_o),
		.flash_dq_oe(dq_oe), .reset_powerdown_n(rp_n), .high_voltage_unlock_en(hv),
		.flash_wp_n(wp_n), .flash_vpp_en(vpp)
	);
	fbepc_flash_model flash (
		.hclk(hclk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fa), .din(dq_o),
		.rp_n(rp_n), .hv(hv), .wp_n(wp_n), .vpp(vpp), .fail(fail), .dout(dq_i)
	);
	// ==========
	// tasks
	task finish_test;
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {28'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task op(input logic [2:0] o, input logic [3:0] ctl);
		bus(1'b1, 4'h0, {20'h0, ctl, 5'h00, o});
	endtask
	task idle;
		for (int n = 0; n < 3000; n++) begin
			bus(1'b0, 4'h8, 32'h0);
			if (q[0] === 1'b0)
				return;
		end
		chk(q, 32'h0, "busy stuck");
	endtask
	task erase(input logic [3:0] ctl, input logic [17:0] a, input logic [7:0] sr);
		bus(1'b1, 4'h4, {14'h0, a});
		op(3'h1, ctl);
		idle;
		chk(q[15:0], {sr, 3'h0, sr[3], sr[5], 3'h0}, "erase stat");
		op(3'h5, 4'h5);
		idle;
	endtask
	task rd_arr(input logic [17:0] a, input logic [15:0] d);
		bus(1'b1, 4'h4, {14'h0, a});
		op(3'h6, 4'h5);
		idle;
		bus(1'b0, 4'hC, 32'h0);
		chk(q[15:0], d, "array");
	endtask
	// ==========
	// clock, watchdog and tests
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	initial begin
		repeat (50000) @(posedge hclk);
		fail_count++;
		finish_test;
	end
	initial begin
		hresetn = 1'b0;
		fail = 1'b0;
		htrans = 2'h0;
		haddr = '0;
		hwrite = 1'b0;
		hwdata = '0;
		repeat (10) @(posedge hclk);
		chk({rp_n, ce_n}, 2'b01, "pd pins");
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 4'h0, 32'h0);
		chk(q, 32'h900, "ctrl rst");
		chk(hresp, 1'b0, "bus response");
		op(3'h0, 4'h5);
		op(3'h4, 4'h5);
		idle;
		chk(q[15:8], 8'h80, "sr up");
		erase(4'h5, 18'h10000, 8'h80);
		rd_arr(18'h10000, 16'hFFFF);
		rd_arr(18'h08123, 16'h8123);
		fail <= 1'b1;
		erase(4'h5, 18'h10000, 8'hA0);
		fail <= 1'b0;
		erase(4'h1, 18'h10000, 8'hA8);
		erase(4'h4, 18'h38000, 8'hA0);
		erase(4'h4, 18'h10000, 8'h80);
		erase(4'h6, 18'h38000, 8'h80);
		bus(1'b1, 4'h4, 32'h10000);
		op(3'h1, 4'h5);
		op(3'h2, 4'h5);
		idle;
		chk(q[2:0], 3'h2, "susp");
		op(3'h1, 4'h5);
		bus(1'b0, 4'h8, 32'h0);
		chk(q[2:0], 3'h6, "refuse");
		rd_arr(18'h08123, 16'h8123);
		op(3'h3, 4'h5);
		idle;
		chk(q[15:0], 16'h8000, "resume");
		bus(1'b1, 4'h4, 32'h10000);
		op(3'h1, 4'h5);
		op(3'h0, 4'hD);
		bus(1'b0, 4'h8, 32'h0);
		chk(rp_n, 1'b0, "rp low");
		op(3'h0, 4'h5);
		idle;
		op(3'h4, 4'h5);
		idle;
		chk(q[15:8], 8'h80, "sr clr");
		finish_test;
	end
endmodule
